// ===== rtl/tear_scan_map.svh
// command codes, field positions, reset values for the tear/scan/scroll command block
// assumes a byte-wide command stream already split into command and parameter bytes
`ifndef TEAR_SCAN_MAP_SVH
`define TEAR_SCAN_MAP_SVH

// command codes
`define CMD_TEAR_LINE_DISABLE 8'h34
`define CMD_TEAR_LINE_ENABLE 8'h35
`define CMD_MEMORY_SCAN_ORDER 8'h36
`define CMD_SCROLL_START 8'h37

// memory scan order byte field positions
`define SCAN_BIT_ROW_ORDER 7
`define SCAN_BIT_COL_ORDER 6
`define SCAN_BIT_EXCHANGE 5
`define SCAN_BIT_VERT_ORDER 4
`define SCAN_BIT_BGR 3
`define SCAN_FIELD_HI 7
`define SCAN_FIELD_LO 3

// tear enable parameter: mode bit position
`define TEAR_MODE_BIT 0

// reset values
`define SCAN_ORDER_RESET 5'h00
`define SCROLL_START_RESET 16'h0000
`define TEAR_MODE_RESET 1'b0
`define TEAR_ENABLE_RESET 1'b0

`endif

// ===== rtl/tear_scan_pkg.sv
// types shared by the tear/scan/scroll command block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package tear_scan_pkg;

   // one byte from the host interface decoder
   typedef struct packed {
      logic stb;         // one-cycle write strobe
      logic dcx;         // 0 command byte, 1 parameter byte
      logic [7:0] data;  // byte value
   } host_wr_t;

   // memory scan order settings, bit 7 down to bit 3 of the byte
   typedef struct packed {
      logic row_addr_order;
      logic col_addr_order;
      logic row_col_exchange;
      logic vertical_refresh_order;
      logic bgr_order;
   } scan_order_t;

   // command decoder states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TEAR_PARAM = 3'b001,
      ST_SCAN_PARAM = 3'b010,
      ST_SCROLL_HI = 3'b011,
      ST_SCROLL_LO = 3'b100
   } cmd_state_t;

endpackage

`default_nettype wire

// ===== rtl/tear_signal_gen.sv
// tear signal pin generator: turns panel blanking into the host-facing sync pin
// assumes blanking inputs come from the timing generator on the same clock
`default_nettype none

module tear_signal_gen (
   input wire logic mclk_i,            // system clock
   input wire logic resetn_i,          // async reset, active low
   input wire logic enable_i,          // tear output enabled
   input wire logic mode_i,            // 0 vertical only, 1 vertical and horizontal
   input wire logic sleep_i,           // sleep-in state
   input wire logic vblank_i,          // vertical blanking level
   input wire logic hblank_i,          // horizontal blanking level
   output logic tear_signal_pin_o      // sync pin, inactive low
);

   logic pin_nxt; // next pin level

   // pin logic ignores the vertical refresh order on purpose, so the
   // host sees identical pulses whichever way the panel scans
   always_comb begin
      pin_nxt = 1'b0;
      if (enable_i && !sleep_i) begin
         pin_nxt = vblank_i || (mode_i && hblank_i);
      end
   end

   // registered so the pin never glitches on blanking edges
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tear_signal_pin_o <= 1'b0;
      end else begin
         tear_signal_pin_o <= pin_nxt;
      end
   end

endmodule // tear_signal_gen

`default_nettype wire

// ===== rtl/tear_scan_scroll_cmds.sv
// command interpreter for tear line control, memory scan order and scroll start
// assumes an upstream decoder delivering one byte per strobe on mclk_i,
// and a panel timing generator on the same clock giving blanking and frame start
//
// Function
// - disable command drives tear pin low
// - repeated disable changes nothing
// - enable command; pulses ignore vertical order
// - mode zero: vertical blanking only
// - mode one: vertical and horizontal blanking
// - sleep-in with enable holds pin low
// - any reset: tear off, mode zero
// - repeated enable has no effect
// - tear commands accepted in every state
// - scan order byte, bits 7..3, reset zero
// - row, column, exchange bits steer addressing
// - vertical order bit sets refresh direction
// - colour bit: zero RGB, one BGR
// - scan byte write touches nothing else
// - scroll pointer: two bytes, high first
// - host pairs pointer with scroll area definition
// - scroll pointer command starts vertical scrolling
// - new pointer visible from next scan
// - fixed area from top or bottom
`include "tear_scan_map.svh"
`default_nettype none

module tear_scan_scroll_cmds #(
   parameter int PANEL_LINES = 162          // display lines of the selected panel size
) (
   input wire logic mclk_i,                               // system clock, 100 MHz
   input wire logic resetn_i,                             // hardware reset, async, active low
   input wire tear_scan_pkg::host_wr_t host_wr_i,         // host command/parameter bytes
   input wire logic soft_reset_i,                         // software reset pulse
   input wire logic sleep_in_i,                           // sleep-in state level
   input wire logic vblank_i,                             // vertical blanking level
   input wire logic hblank_i,                             // horizontal blanking level
   input wire logic frame_start_i,                        // pulse at start of a panel scan
   input wire logic [15:0] top_fixed_lines_i,             // top fixed area height
   output logic tear_signal_pin_o,                        // tear sync pin, inactive low
   output logic tear_enable_o,                            // tear output enabled flag
   output logic tear_output_mode_o,                       // tear output mode flag
   output tear_scan_pkg::scan_order_t scan_order_o,       // scan order settings
   output logic scroll_mode_o,                            // vertical scrolling active
   output logic [15:0] scroll_start_line_o,               // pointer in use by panel scan
   output logic [15:0] scroll_region_first_o              // first display line after fixed area
);

   import tear_scan_pkg::*;

   cmd_state_t state_r;            // decoder state
   cmd_state_t state_nxt;          // next decoder state
   logic tear_en_r;                // tear output enabled
   logic tear_mode_r;              // tear output mode
   scan_order_t scan_r;            // scan order byte, bits 7..3
   logic [7:0] scroll_hi_r;        // high pointer byte held until low byte arrives
   logic [15:0] scroll_pend_r;     // pointer written but not yet shown
   logic scroll_pend_vld_r;        // a pointer waits for next scan
   logic [15:0] scroll_act_r;      // pointer in use
   logic scroll_mode_r;            // vertical scrolling on
   logic [15:0] region_first_r;    // first line after fixed area, by refresh direction

   logic is_cmd;                   // command byte this cycle
   logic is_par;                   // parameter byte this cycle
   logic tear_par;                 // tear enable parameter taken
   logic scan_par;                 // scan order parameter taken
   logic scroll_lo_par;            // low pointer byte taken

   assign is_cmd = host_wr_i.stb && !host_wr_i.dcx;
   assign is_par = host_wr_i.stb && host_wr_i.dcx;
   assign tear_par = is_par && (state_r == ST_TEAR_PARAM);
   assign scan_par = is_par && (state_r == ST_SCAN_PARAM);
   assign scroll_lo_par = is_par && (state_r == ST_SCROLL_LO);

   // decoder: a command byte always restarts, so a truncated parameter
   // sequence never leaves the block waiting for bytes of an old command
   always_comb begin
      state_nxt = state_r;
      if (is_cmd) begin
         case (host_wr_i.data)
            `CMD_TEAR_LINE_ENABLE: begin
               state_nxt = ST_TEAR_PARAM;
            end
            `CMD_MEMORY_SCAN_ORDER: begin
               state_nxt = ST_SCAN_PARAM;
            end
            `CMD_SCROLL_START: begin
               state_nxt = ST_SCROLL_HI;
            end
            default: begin
               state_nxt = ST_IDLE; // disable and the commands of other blocks take no parameter here
            end
         endcase
      end else if (is_par) begin
         case (state_r)
            ST_SCROLL_HI: begin
               state_nxt = ST_SCROLL_LO; // high byte first
            end
            ST_TEAR_PARAM, ST_SCAN_PARAM, ST_SCROLL_LO: begin
               state_nxt = ST_IDLE;
            end
            default: begin
               state_nxt = ST_IDLE; // stray parameter ignored
            end
         endcase
      end
   end

   // decoder state register; software reset aborts any sequence
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
      end else if (soft_reset_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // tear enable flag: no operating state gates these commands
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tear_en_r <= `TEAR_ENABLE_RESET;
      end else if (soft_reset_i) begin
         tear_en_r <= `TEAR_ENABLE_RESET;
      end else if (is_cmd && host_wr_i.data == `CMD_TEAR_LINE_DISABLE) begin
         tear_en_r <= 1'b0;
      end else if (tear_par) begin
         tear_en_r <= 1'b1;
      end
   end

   // tear mode: a repeated enable while already on leaves the mode alone
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tear_mode_r <= `TEAR_MODE_RESET;
      end else if (soft_reset_i) begin
         tear_mode_r <= `TEAR_MODE_RESET;
      end else if (tear_par && !tear_en_r) begin
         tear_mode_r <= host_wr_i.data[`TEAR_MODE_BIT];
      end
   end

   // scan order byte: only this register changes on its write
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scan_r <= `SCAN_ORDER_RESET;
      end else if (soft_reset_i) begin
         scan_r <= `SCAN_ORDER_RESET;
      end else if (scan_par) begin
         scan_r <= host_wr_i.data[`SCAN_FIELD_HI:`SCAN_FIELD_LO];
      end
   end

   // high pointer byte staging
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scroll_hi_r <= 8'h00;
      end else if (is_par && state_r == ST_SCROLL_HI) begin
         scroll_hi_r <= host_wr_i.data;
      end
   end

   // pending pointer: held back until the panel starts its next scan, so a
   // half-drawn frame never mixes old and new scroll positions
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scroll_pend_r <= `SCROLL_START_RESET;
         scroll_pend_vld_r <= 1'b0;
      end else if (soft_reset_i) begin
         scroll_pend_r <= `SCROLL_START_RESET;
         scroll_pend_vld_r <= 1'b0;
      end else if (scroll_lo_par) begin
         scroll_pend_r <= {scroll_hi_r, host_wr_i.data};
         scroll_pend_vld_r <= 1'b1; // a new write wins over a same-cycle frame start
      end else if (frame_start_i) begin
         scroll_pend_vld_r <= 1'b0;
      end
   end

   // active pointer changes only at a frame start or a hardware or software reset
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scroll_act_r <= `SCROLL_START_RESET;
      end else if (soft_reset_i) begin
         scroll_act_r <= `SCROLL_START_RESET;
      end else if (frame_start_i && scroll_pend_vld_r) begin
         scroll_act_r <= scroll_pend_r;
      end
   end

   // scrolling mode: set by the pointer command itself; leaving it is
   // the business of the display mode commands, which reset here only
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scroll_mode_r <= 1'b0;
      end else if (soft_reset_i) begin
         scroll_mode_r <= 1'b0;
      end else if (is_cmd && host_wr_i.data == `CMD_SCROLL_START) begin
         scroll_mode_r <= 1'b1;
      end
   end

   // fixed area reference: counted from the top for order zero, from the
   // bottom for order one; exchange bit is trusted to be zero by the host
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         region_first_r <= 16'h0000;
      end else if (scan_r.vertical_refresh_order) begin
         region_first_r <= 16'(PANEL_LINES) - 16'h0001 - top_fixed_lines_i;
      end else begin
         region_first_r <= top_fixed_lines_i;
      end
   end

   // pin generator, no dependence on the refresh order
   tear_signal_gen u_tear_gen (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .enable_i(tear_en_r),
      .mode_i(tear_mode_r),
      .sleep_i(sleep_in_i),
      .vblank_i(vblank_i),
      .hblank_i(hblank_i),
      .tear_signal_pin_o(tear_signal_pin_o)
   );

   // outputs; scan fields feed address stepping, refresh direction and colour order
   assign tear_enable_o = tear_en_r;
   assign tear_output_mode_o = tear_mode_r;
   assign scan_order_o = scan_r;
   assign scroll_mode_o = scroll_mode_r;
   assign scroll_start_line_o = scroll_act_r;
   assign scroll_region_first_o = region_first_r;

   // checks on the block's own outputs
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   property p_disable_pin;
      is_cmd && host_wr_i.data == `CMD_TEAR_LINE_DISABLE && !soft_reset_i
         |=> !tear_en_r ##1 !tear_signal_pin_o;
   endproperty
   a_disable_pin: assert property (p_disable_pin)
      else $error("tear pin not low after disable");

   property p_disable_idle;
      is_cmd && host_wr_i.data == `CMD_TEAR_LINE_DISABLE && !tear_en_r && !soft_reset_i
         |=> $stable(tear_mode_r) && $stable(scan_r) && $stable(scroll_act_r) && !tear_en_r;
   endproperty
   a_disable_idle: assert property (p_disable_idle)
      else $error("repeated disable changed state");

   property p_enable;
      is_cmd && host_wr_i.data == `CMD_TEAR_LINE_ENABLE && !soft_reset_i
         ##1 (is_par && !soft_reset_i) |=> tear_en_r;
   endproperty
   a_enable: assert property (p_enable)
      else $error("tear output not enabled");

   property p_vert_only;
      tear_en_r && !tear_mode_r && !sleep_in_i && hblank_i && !vblank_i
         |=> !tear_signal_pin_o;
   endproperty
   a_vert_only: assert property (p_vert_only)
      else $error("horizontal pulse in vertical-only mode");

   property p_both_blank;
      tear_en_r && tear_mode_r && !sleep_in_i && hblank_i |=> tear_signal_pin_o;
   endproperty
   a_both_blank: assert property (p_both_blank)
      else $error("horizontal blanking missing on pin");

   property p_sleep_low;
      sleep_in_i [*2] |-> !tear_signal_pin_o;
   endproperty
   a_sleep_low: assert property (p_sleep_low)
      else $error("tear pin high in sleep");

   property p_soft_reset;
      soft_reset_i |=> !tear_en_r && !tear_mode_r && scan_r == 5'h00 && !scroll_mode_r;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("software reset left state set");

   property p_enable_again;
      tear_par && tear_en_r && !soft_reset_i |=> $stable(tear_mode_r) && tear_en_r;
   endproperty
   a_enable_again: assert property (p_enable_again)
      else $error("repeated enable changed mode");

   property p_scan_write;
      scan_par && !soft_reset_i
         |=> scan_r == $past(host_wr_i.data[7:3]) && $stable(tear_en_r) && $stable(tear_mode_r);
   endproperty
   a_scan_write: assert property (p_scan_write)
      else $error("scan order byte not stored alone");

   property p_pointer_hold;
      scroll_lo_par && !soft_reset_i && !frame_start_i
         |=> scroll_pend_r == {$past(scroll_hi_r), $past(host_wr_i.data)}
             && $stable(scroll_act_r);
   endproperty
   a_pointer_hold: assert property (p_pointer_hold)
      else $error("pointer shown before next scan");

   property p_scroll_on;
      is_cmd && host_wr_i.data == `CMD_SCROLL_START && !soft_reset_i |=> scroll_mode_r;
   endproperty
   a_scroll_on: assert property (p_scroll_on)
      else $error("scrolling not started");

   property p_region_top;
      !scan_r.vertical_refresh_order && $stable(scan_r)
         |=> region_first_r == $past(top_fixed_lines_i);
   endproperty
   a_region_top: assert property (p_region_top)
      else $error("fixed area not counted from top");

   property p_region_bottom;
      scan_r.vertical_refresh_order
         |=> region_first_r == 16'(PANEL_LINES) - 16'h0001 - $past(top_fixed_lines_i);
   endproperty
   a_region_bottom: assert property (p_region_bottom)
      else $error("fixed area not counted from bottom");

   property p_frame_apply;
      frame_start_i && scroll_pend_vld_r && !soft_reset_i
         |=> scroll_start_line_o == $past(scroll_pend_r);
   endproperty
   a_frame_apply: assert property (p_frame_apply)
      else $error("pending pointer not applied at scan start");

   property p_enable_mode;
      tear_par && !tear_en_r && !soft_reset_i
         |=> tear_mode_r == $past(host_wr_i.data[`TEAR_MODE_BIT]);
   endproperty
   a_enable_mode: assert property (p_enable_mode)
      else $error("tear mode not taken from parameter bit 0");

   // a disabled output must never leave a pulse behind on the pin
   property p_pin_off;
      !tear_en_r |=> !tear_signal_pin_o;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("tear pin high while output disabled");

endmodule // tear_scan_scroll_cmds

`default_nettype wire

// ===== tb/host_cmd_model.sv
// host side model: writes command and parameter bytes and issues software reset
// assumes the bench owns the clock and calls these tasks from a single process
`default_nettype none

module host_cmd_model (
   input wire logic mclk_i,                    // system clock
   output tear_scan_pkg::host_wr_t host_wr_o,  // byte stream towards the device
   output logic soft_reset_o                   // software reset pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   import tear_scan_pkg::*;

   // quiet bus from time zero
   initial begin
      host_wr_o = '0;
      soft_reset_o = 1'b0;
   end

   // one byte per call; consecutive calls strobe on consecutive edges
   task automatic put_byte(input logic dcx, input logic [7:0] data);
      @(posedge mclk_i);
      host_wr_o <= '{stb: 1'b1, dcx: dcx, data: data};
   endtask

   // strobe off; idle data is inverted so nothing can lean on a stale byte
   task automatic idle();
      @(posedge mclk_i);
      host_wr_o <= '{stb: 1'b0, dcx: ~host_wr_o.dcx, data: ~host_wr_o.data};
   endtask

   // a command and its parameters, pointer high byte first
   task automatic send(input logic [7:0] cmd, input int n, input logic [15:0] par);
      put_byte(1'b0, cmd);
      if (n == 2) put_byte(1'b1, par[15:8]);
      if (n >= 1) put_byte(1'b1, par[7:0]);
      idle();
   endtask

   // software reset, one cycle wide
   task automatic soft_reset();
      @(posedge mclk_i);
      soft_reset_o <= 1'b1;
      @(posedge mclk_i);
      soft_reset_o <= 1'b0;
   endtask
endmodule // host_cmd_model

`default_nettype wire

// ===== tb/tear_scan_scroll_cmds_bench.sv
// self-checking bench for the tear/scan/scroll command interpreter
// assumes host_cmd_model and the design compiled before it
`default_nettype none

module tear_scan_scroll_cmds_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tear_scan_pkg::*;

   localparam int LINES = 162;   // panel size handed to the design
   typedef struct {
      logic [7:0] cmd;
      int n;
      logic [15:0] par;
      logic en;
      logic mode;
      logic [4:0] scan;
      logic scroll;
   } row_t;

   logic mclk = 1'b0;            // system clock
   logic resetn = 1'b0;          // hardware reset, active low
   logic vblank = 1'b0;          // panel blanking levels
   logic hblank = 1'b0;
   logic sleep_in = 1'b0;        // sleep-in state
   logic frame_start = 1'b0;     // panel scan start pulse
   logic [15:0] fixed_lines = 16'h0005;  // stands in for the scroll area block
   host_wr_t host_wr;            // byte stream from the host model
   logic soft_reset;             // software reset from the host model
   logic pin, en, mode, scroll;  // design outputs
   scan_order_t scan;
   logic [15:0] line, region;
   int error_cnt = 0;
   int tests_run = 0;

   // command rows run in order; state carries over from row to row
   row_t rows[8] = '{
      '{8'h34, 0, 16'h0000, 1'b0, 1'b0, 5'h00, 1'b0},  // disable while already off
      '{8'h36, 1, 16'h00A8, 1'b0, 1'b0, 5'h15, 1'b0},
      '{8'h36, 1, 16'h0057, 1'b0, 1'b0, 5'h0A, 1'b0},  // low bits dropped
      '{8'h35, 1, 16'h0000, 1'b1, 1'b0, 5'h0A, 1'b0},
      '{8'h35, 1, 16'h00FF, 1'b1, 1'b0, 5'h0A, 1'b0},  // repeat enable keeps mode
      '{8'h34, 0, 16'h0000, 1'b0, 1'b0, 5'h0A, 1'b0},
      '{8'h35, 1, 16'h0002, 1'b1, 1'b0, 5'h0A, 1'b0},  // only bit 0 picks mode
      '{8'h37, 2, 16'h1234, 1'b1, 1'b0, 5'h0A, 1'b1}
   };

   // 100 MHz clock
   always #5 mclk = ~mclk;

   host_cmd_model host_cmd_model_inst (
      .mclk_i(mclk),
      .host_wr_o(host_wr),
      .soft_reset_o(soft_reset)
   );

   tear_scan_scroll_cmds #(.PANEL_LINES(LINES)) tear_scan_scroll_cmds_inst (
      .mclk_i(mclk),
      .resetn_i(resetn),
      .host_wr_i(host_wr),
      .soft_reset_i(soft_reset),
      .sleep_in_i(sleep_in),
      .vblank_i(vblank),
      .hblank_i(hblank),
      .frame_start_i(frame_start),
      .top_fixed_lines_i(fixed_lines),
      .tear_signal_pin_o(pin),
      .tear_enable_o(en),
      .tear_output_mode_o(mode),
      .scan_order_o(scan),
      .scroll_mode_o(scroll),
      .scroll_start_line_o(line),
      .scroll_region_first_o(region)
   );

   // compare and count; four-state inequality so unknowns never pass
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // let k edges land, then look away from the edge
   task automatic settle(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   // command plus its answer latency
   task automatic run(input logic [7:0] cmd, input int n, input logic [15:0] par);
      host_cmd_model_inst.send(cmd, n, par);
      settle(1);
   endtask

   // panel levels change on an edge; the pin follows one edge later
   task automatic panel(input logic v, input logic h, input logic s, input logic exp);
      @(posedge mclk);
      vblank <= v;
      hblank <= h;
      sleep_in <= s;
      settle(2);
      check("tear pin", 16'(pin), 16'(exp));
   endtask

   // one scan start pulse, then the pointer in use
   task automatic frame(input logic [15:0] exp);
      @(posedge mclk);
      frame_start <= 1'b1;
      @(posedge mclk);
      frame_start <= 1'b0;
      settle(1);
      check("scroll line", line, exp);
   endtask

   // the single place where the run ends
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      conclude();
   end

   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      settle(1);
      check("reset state", {en, mode, scroll, pin, 7'h00, scan}, 16'h0000);
      check("reset line", line, 16'h0000);
      foreach (rows[i]) begin
         run(rows[i].cmd, rows[i].n, rows[i].par);
         check("tear enable", 16'(en), 16'(rows[i].en));
         if (rows[i].en) check("tear mode", 16'(mode), 16'(rows[i].mode));
         check("scan order", 16'(scan), 16'(rows[i].scan));
         check("scroll mode", 16'(scroll), 16'(rows[i].scroll));
         check("pointer held", line, 16'h0000);
      end
      frame(16'h1234);
      // a lone high byte cut off by a command must not reach the pointer
      host_cmd_model_inst.put_byte(1'b0, 8'h37);
      host_cmd_model_inst.put_byte(1'b1, 8'hAB);
      run(8'h36, 1, 16'h0008);  // exchange bit kept clear while scrolling
      check("scan after abort", 16'(scan), 16'h0001);
      frame(16'h1234);
      // mode zero: horizontal blanking alone gives nothing
      panel(1'b0, 1'b1, 1'b0, 1'b0);
      panel(1'b1, 1'b0, 1'b0, 1'b1);
      // vertical order flip must not move the pin, but moves the fixed area
      run(8'h36, 1, 16'h0010);
      settle(2);
      check("pin after order", 16'(pin), 16'h0001);
      check("region bottom", region, 16'(LINES - 1 - 5));
      run(8'h36, 1, 16'h0000);
      settle(2);
      check("region top", region, 16'h0005);
      // sleep holds the pin low, commands still accepted
      panel(1'b1, 1'b0, 1'b1, 1'b0);
      run(8'h34, 0, 16'h0000);
      check("off in sleep", 16'(en), 16'h0000);
      run(8'h35, 1, 16'h0001);
      check("on in sleep", {15'h0000, en}, 16'h0001);
      panel(1'b0, 1'b1, 1'b1, 1'b0);
      panel(1'b0, 1'b1, 1'b0, 1'b1);
      run(8'h34, 0, 16'h0000);
      settle(1);
      check("pin after off", 16'(pin), 16'h0000);
      // software reset from a busy state
      run(8'h35, 1, 16'h0001);
      run(8'h36, 1, 16'h00D8);
      host_cmd_model_inst.soft_reset();
      settle(2);
      check("soft reset", {en, mode, scroll, pin, 7'h00, scan}, 16'h0000);
      check("soft reset line", line, 16'h0000);
      // hardware reset in mid-run from a busy state, then a command right after release
      run(8'h35, 1, 16'h0001);
      run(8'h37, 2, 16'h00C3);
      frame(16'h00C3);
      @(posedge mclk);
      resetn <= 1'b0;
      settle(1);
      check("hw reset", {en, mode, scroll, pin, 7'h00, scan}, 16'h0000);
      check("hw reset line", line, 16'h0000);
      check("hw reset region", region, 16'h0000);
      @(posedge mclk);
      resetn <= 1'b1;
      run(8'h36, 1, 16'h00A8);
      check("scan after release", 16'(scan), 16'h0015);
      check("off after release", {15'h0000, en}, 16'h0000);
      conclude();
   end
endmodule // tear_scan_scroll_cmds_bench

`default_nettype wire
